// ### nco_host_model.sv
module nco_host_model (
  input  wire logic        clock,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_valid,
  output      logic        wr_en,
  output      logic        rd_en,
  output      logic [11:0] addr,
  output      logic [31:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    addr    = 12'h000;
    wr_data = 32'h0;
  end
  // ==========================================================
  // one-cycle strobes; idle data shows the inverse of the last word
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en   <= 1'b0;
    wr_data <= ~d;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    @(posedge clock);
    if (rd_valid === 1'b1) begin
      d = rd_data;
    end else begin
      d = 32'hxxxxxxxx;
    end
  endtask : rd
  // poll init state before any other access
  task automatic wait_init(output logic ok);
    logic [31:0] v;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      rd(12'h270, v);
      ok = (v[0] === 1'b1);
    end
  endtask : wait_init
endmodule : nco_host_model

// ### nco_preset_pkg.sv
package nco_preset_pkg;
  // ==========================================================
  // register offsets
  localparam logic [11:0] phase_b1_offset    = 12'h24c;
  localparam logic [11:0] freq_b2_offset     = 12'h250;
  localparam logic [11:0] phase_b2_offset    = 12'h254;
  localparam logic [11:0] freq_b3_offset     = 12'h258;
  localparam logic [11:0] phase_b3_offset    = 12'h25c;
  localparam logic [11:0] init_state_offset  = 12'h270;
  localparam logic [11:0] revision_offset    = 12'h297;
  localparam logic [11:0] noise_ctrl_offset  = 12'h2a2;
  localparam logic [11:0] sysref_cal_offset  = 12'h2b0;
  // ==========================================================
  // widths and reset values
  localparam int          addr_width         = 12;
  localparam int          data_width         = 32;
  localparam logic [15:0] phase_reset        = 16'h0000;
  localparam logic [31:0] freq_reset         = 32'hc0000000;
  localparam logic [7:0]  noise_ctrl_reset   = 8'h00;
  localparam logic [7:0]  sysref_cal_reset   = 8'h00;
  // ==========================================================
  // field positions
  localparam int          init_done_bit      = 0;
  localparam int          revision_msb       = 4;
  localparam int          digital_supply_bit = 5;
  localparam int          second_supply_bit  = 4;
  localparam int          sysref_cal_bit     = 0;
  // arbitrary neutral revision value
  localparam logic [4:0]  revision_default   = 5'h1f;
endpackage : nco_preset_pkg

// ### nco_preset_props.sv
module nco_preset_props (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [11:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic        interleaved_mode,
  input wire logic [31:0] freq_a2,
  input wire logic [15:0] phase_a1,
  input wire logic [31:0] rd_data,
  input wire logic        rd_valid,
  input wire logic [31:0] freq_b2_eff,
  input wire logic [15:0] phase_b1_eff,
  input wire logic        digital_supply_noise_suppress,
  input wire logic        second_supply_noise_suppress,
  input wire logic        sysref_cal_start
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // register access and control outputs
  a_read_answer: assert property (rd_en |=> rd_valid) else $error("read not answered");
  a_read_no_spur: assert property (!rd_en |=> !rd_valid) else $error("spurious read valid");
  a_read_idle_zero: assert property (!rd_valid |-> rd_data == 32'h0)
    else $error("read data not zero while idle");
  a_digital_supply: assert property (wr_en && addr == 12'h2a2 |-> ##2
    digital_supply_noise_suppress == $past(wr_data[5], 2)) else $error("digital enable wrong");
  a_second_supply: assert property (wr_en && addr == 12'h2a2 |-> ##2
    second_supply_noise_suppress == $past(wr_data[4], 2)) else $error("second enable wrong");
  a_cal_one_cycle: assert property (sysref_cal_start |=> !sysref_cal_start)
    else $error("calibration start longer than one cycle");
  a_cal_cause: assert property (sysref_cal_start |->
    $past(wr_en && addr == 12'h2b0 && wr_data[0])) else $error("calibration start uncaused");
  a_mode_substitute: assert property (interleaved_mode |=> freq_b2_eff == $past(freq_a2)
    && phase_b1_eff == $past(phase_a1)) else $error("channel a not substituted");
endmodule : nco_preset_props

bind nco_preset_regs nco_preset_props i_props (.clock, .rstn, .wr_en, .rd_en, .addr,
  .wr_data, .interleaved_mode, .freq_a2, .phase_a1, .rd_data, .rd_valid, .freq_b2_eff,
  .phase_b1_eff, .digital_supply_noise_suppress, .second_supply_noise_suppress,
  .sysref_cal_start);

// ### nco_preset_regs.sv
module nco_preset_regs #(
  parameter logic [4:0] revision_code = nco_preset_pkg::revision_default
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        init_logic_done,
  input  wire logic        interleaved_mode,
  input  wire logic [31:0] freq_a2,
  input  wire logic [31:0] freq_a3,
  input  wire logic [15:0] phase_a1,
  input  wire logic [15:0] phase_a2,
  input  wire logic [15:0] phase_a3,
  output logic      [31:0] rd_data,
  output logic             rd_valid,
  output logic      [31:0] freq_b2_eff,
  output logic      [31:0] freq_b3_eff,
  output logic      [15:0] phase_b1_eff,
  output logic      [15:0] phase_b2_eff,
  output logic      [15:0] phase_b3_eff,
  output logic             digital_supply_noise_suppress,
  output logic             second_supply_noise_suppress,
  output logic             sysref_cal_start
);
  // ==========================================================
  // reset release
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ==========================================================
  // preset storage
  logic [15:0] phase_b1;
  logic [15:0] phase_b2;
  logic [15:0] phase_b3;
  logic [31:0] freq_b2;
  logic [31:0] freq_b3;

  preset_slot #(
    .width    (16),
    .reset_val(nco_preset_pkg::phase_reset)
  ) u_phase_b1 (
    .clock  (clock),
    .rst_n  (rst_n_reg),
    .wr_en  (wr_en && addr == nco_preset_pkg::phase_b1_offset),
    .wr_data(wr_data[15:0]),
    .value  (phase_b1)
  );
  preset_slot #(
    .width    (16),
    .reset_val(nco_preset_pkg::phase_reset)
  ) u_phase_b2 (
    .clock  (clock),
    .rst_n  (rst_n_reg),
    .wr_en  (wr_en && addr == nco_preset_pkg::phase_b2_offset),
    .wr_data(wr_data[15:0]),
    .value  (phase_b2)
  );
  preset_slot #(
    .width    (16),
    .reset_val(nco_preset_pkg::phase_reset)
  ) u_phase_b3 (
    .clock  (clock),
    .rst_n  (rst_n_reg),
    .wr_en  (wr_en && addr == nco_preset_pkg::phase_b3_offset),
    .wr_data(wr_data[15:0]),
    .value  (phase_b3)
  );
  preset_slot #(
    .width    (32),
    .reset_val(nco_preset_pkg::freq_reset)
  ) u_freq_b2 (
    .clock  (clock),
    .rst_n  (rst_n_reg),
    .wr_en  (wr_en && addr == nco_preset_pkg::freq_b2_offset),
    .wr_data(wr_data),
    .value  (freq_b2)
  );
  preset_slot #(
    .width    (32),
    .reset_val(nco_preset_pkg::freq_reset)
  ) u_freq_b3 (
    .clock  (clock),
    .rst_n  (rst_n_reg),
    .wr_en  (wr_en && addr == nco_preset_pkg::freq_b3_offset),
    .wr_data(wr_data),
    .value  (freq_b3)
  );

  // ==========================================================
  // control registers
  logic [7:0] noise_ctrl_reg;
  logic [7:0] noise_ctrl_next;
  logic [7:0] sysref_cal_reg;
  logic [7:0] sysref_cal_next;
  logic       cal_start_next;
  always_comb begin
    noise_ctrl_next = noise_ctrl_reg;
    sysref_cal_next = sysref_cal_reg;
    if (wr_en && addr == nco_preset_pkg::noise_ctrl_offset) begin
      noise_ctrl_next = wr_data[7:0];
    end
    if (wr_en && addr == nco_preset_pkg::sysref_cal_offset) begin
      sysref_cal_next = wr_data[7:0];
    end
    cal_start_next = sysref_cal_next[nco_preset_pkg::sysref_cal_bit] &&
                     !sysref_cal_reg[nco_preset_pkg::sysref_cal_bit];
  end
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      noise_ctrl_reg   <= nco_preset_pkg::noise_ctrl_reset;
      sysref_cal_reg   <= nco_preset_pkg::sysref_cal_reset;
      sysref_cal_start <= 1'b0;
    end else begin
      noise_ctrl_reg   <= noise_ctrl_next;
      sysref_cal_reg   <= sysref_cal_next;
      sysref_cal_start <= cal_start_next;
    end
  end

  // ==========================================================
  // init done synchroniser
  logic init_s1_reg;
  logic init_s2_reg;
  logic init_s3_reg;
  logic init_done_reg;
  logic init_done_next;
  always_comb begin
    init_done_next = init_done_reg;
    if (init_s2_reg == init_s3_reg) begin
      init_done_next = init_s3_reg;
    end
  end
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      init_s1_reg   <= 1'b0;
      init_s2_reg   <= 1'b0;
      init_s3_reg   <= 1'b0;
      init_done_reg <= 1'b0;
    end else begin
      init_s1_reg   <= init_logic_done;
      init_s2_reg   <= init_s1_reg;
      init_s3_reg   <= init_s2_reg;
      init_done_reg <= init_done_next;
    end
  end

  // ==========================================================
  // outputs to oscillator and supplies
  logic [31:0] freq_b2_next;
  logic [31:0] freq_b3_next;
  logic [15:0] phase_b1_next;
  logic [15:0] phase_b2_next;
  logic [15:0] phase_b3_next;
  always_comb begin
    freq_b2_next  = interleaved_mode ? freq_a2  : freq_b2;
    freq_b3_next  = interleaved_mode ? freq_a3  : freq_b3;
    phase_b1_next = interleaved_mode ? phase_a1 : phase_b1;
    phase_b2_next = interleaved_mode ? phase_a2 : phase_b2;
    phase_b3_next = interleaved_mode ? phase_a3 : phase_b3;
  end
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      freq_b2_eff                   <= nco_preset_pkg::freq_reset;
      freq_b3_eff                   <= nco_preset_pkg::freq_reset;
      phase_b1_eff                  <= nco_preset_pkg::phase_reset;
      phase_b2_eff                  <= nco_preset_pkg::phase_reset;
      phase_b3_eff                  <= nco_preset_pkg::phase_reset;
      digital_supply_noise_suppress <= 1'b0;
      second_supply_noise_suppress  <= 1'b0;
    end else begin
      freq_b2_eff                   <= freq_b2_next;
      freq_b3_eff                   <= freq_b3_next;
      phase_b1_eff                  <= phase_b1_next;
      phase_b2_eff                  <= phase_b2_next;
      phase_b3_eff                  <= phase_b3_next;
      digital_supply_noise_suppress <=
        noise_ctrl_reg[nco_preset_pkg::digital_supply_bit];
      second_supply_noise_suppress  <=
        noise_ctrl_reg[nco_preset_pkg::second_supply_bit];
    end
  end

  // ==========================================================
  // read path
  logic [31:0] rd_data_next;
  always_comb begin
    rd_data_next = 32'h00000000;
    case (addr)
      nco_preset_pkg::phase_b1_offset:   rd_data_next = {16'h0000, phase_b1};
      nco_preset_pkg::freq_b2_offset:    rd_data_next = freq_b2;
      nco_preset_pkg::phase_b2_offset:   rd_data_next = {16'h0000, phase_b2};
      nco_preset_pkg::freq_b3_offset:    rd_data_next = freq_b3;
      nco_preset_pkg::phase_b3_offset:   rd_data_next = {16'h0000, phase_b3};
      nco_preset_pkg::init_state_offset: rd_data_next = {31'h00000000, init_done_reg};
      nco_preset_pkg::revision_offset:   rd_data_next = {27'h0000000, revision_code};
      nco_preset_pkg::noise_ctrl_offset: rd_data_next = {24'h000000, noise_ctrl_reg};
      nco_preset_pkg::sysref_cal_offset: rd_data_next = {24'h000000, sysref_cal_reg};
      default:                           rd_data_next = 32'h00000000;
    endcase
  end
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rd_data  <= 32'h00000000;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= rd_en ? rd_data_next : 32'h00000000;
      rd_valid <= rd_en;
    end
  end
endmodule : nco_preset_regs

// ### preset_slot.sv
// ==========================================================
// one read/write preset register with reset value
module preset_slot #(
  parameter int               width      = 16,
  parameter logic [width-1:0] reset_val  = '0
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [width-1:0] wr_data,
  output      logic [width-1:0] value
);
  if (width < 1) begin : g_width_check
    $error("preset_slot width must be at least one");
  end
  logic [width-1:0] value_next;
  always_comb begin
    value_next = wr_en ? wr_data : value;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      value <= reset_val;
    end else begin
      value <= value_next;
    end
  end
endmodule : preset_slot

// ### tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, rstn = 1'b0, init_logic_done = 1'b0, interleaved_mode = 1'b0;
  logic [31:0] freq_a2 = 32'h1234_5678, freq_a3 = 32'h8765_4321;
  logic [15:0] phase_a1 = 16'h1111, phase_a2 = 16'h2222, phase_a3 = 16'h3333;
  logic        wr_en, rd_en, rd_valid, ok, sysref_cal_start;
  logic        digital_supply_noise_suppress, second_supply_noise_suppress;
  logic [11:0] addr;
  logic [31:0] wr_data, rd_data, v, freq_b2_eff, freq_b3_eff;
  logic [15:0] phase_b1_eff, phase_b2_eff, phase_b3_eff;
  int          fails = 0, checked = 0, cycles = 0;
  logic [11:0] ta [10] = '{12'h24c, 12'h250, 12'h254, 12'h258, 12'h25c, 12'h270, 12'h297,
                           12'h2a2, 12'h2b0, 12'h2a0};
  logic [31:0] tr [10] = '{32'h0, 32'hc0000000, 32'h0, 32'hc0000000, 32'h0, 32'h1,
                           32'h0b, 32'h0, 32'h0, 32'h0};
  logic [31:0] tm [10] = '{32'hffff, 32'hffffffff, 32'hffff, 32'hffffffff, 32'hffff,
                           32'h0, 32'h0, 32'hff, 32'hff, 32'h0};
  logic [3:0]  cal_wr  = 4'hb;
  logic [3:0]  cal_exp = 4'h9;
  // arbitrary revision value
  nco_preset_regs #(.revision_code(5'h0b)) i_dut (.clock, .rstn, .wr_en, .rd_en, .addr,
    .wr_data, .init_logic_done, .interleaved_mode, .freq_a2, .freq_a3, .phase_a1, .phase_a2,
    .phase_a3, .rd_data, .rd_valid, .freq_b2_eff, .freq_b3_eff, .phase_b1_eff, .phase_b2_eff,
    .phase_b3_eff, .digital_supply_noise_suppress, .second_supply_noise_suppress,
    .sysref_cal_start);
  nco_host_model i_host (.clock, .rd_data, .rd_valid, .wr_en, .rd_en, .addr, .wr_data);
  // ==========================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      test_done();
    end
  end
  // ==========================================================
  // test sequence
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    i_host.rd(12'h270, v);
    chk(v, 32'h0);
    init_logic_done <= 1'b1;
    i_host.wait_init(ok);
    chk({31'h0, ok}, 32'h1);
    for (int i = 0; i < 10; i++) begin
      i_host.rd(ta[i], v);
      chk(v, tr[i]);
      i_host.wr(ta[i], 32'ha5a5_5a5a);
      i_host.rd(ta[i], v);
      chk(v, (32'ha5a5_5a5a & tm[i]) | (tr[i] & ~tm[i]));
    end
    chk({30'h0, digital_supply_noise_suppress, second_supply_noise_suppress}, 32'h1);
    i_host.wr(12'h2a2, 32'h30);
    repeat (2) @(posedge clock);
    chk({30'h0, digital_supply_noise_suppress, second_supply_noise_suppress}, 32'h3);
    i_host.wr(12'h2a2, 32'hcf);
    repeat (2) @(posedge clock);
    chk({30'h0, digital_supply_noise_suppress, second_supply_noise_suppress}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      i_host.wr(12'h2b0, {31'h0, cal_wr[i]});
      @(posedge clock);
      chk({31'h0, sysref_cal_start}, {31'h0, cal_exp[i]});
    end
    interleaved_mode <= 1'b1;
    repeat (3) @(posedge clock);
    chk({phase_b1_eff, phase_b2_eff}, {phase_a1, phase_a2});
    chk(freq_b3_eff, freq_a3);
    interleaved_mode <= 1'b0;
    repeat (3) @(posedge clock);
    chk(freq_b2_eff, 32'ha5a5_5a5a);
    chk({16'h0, phase_b3_eff}, 32'h5a5a);
    test_done();
  end
endmodule : tb
